// ==== brpf_pkg.sv ====
// Summary of operation
// R1: an 8-bit read/write interrupt routing byte resets to zero and only records the controller input that irq_out_n drives.
// R2: the read-only interrupt pin byte reads 00h in forward operation and 01h in reverse operation.
// R3: the read-only minimum grant byte in bits 23:16 resets to zero and counts half-microsecond burst units.
// R4: the read-only maximum latency byte in bits 31:24 resets to zero and counts quarter-microsecond units.
// R5: control bit 0 at zero parks the secondary grant on the last master, at one on the bridge's own port.
// R6: control bit 1 at zero enables dynamic prefetch control for upstream reads, at one disables it.
// R7: control bit 2 at zero enables completion data prediction for upstream reads, at one disables it.
// R8: the read-multiple field in bits 5:4 resets to 10 for full prefetch, 00 gives one line, only in prefetchable range.
// R9: read-multiple value 01 keeps leftover data after the bridge disconnects, 11 keeps it on either termination.
// R10: the read-line field in bits 7:6 resets to 00 for one line, 10 gives full prefetch, only in prefetchable range.
// R11: read-line value 01 keeps leftover data after the master disconnects, 11 keeps it on either termination.
// R12: in PCI-X mode both prefetch fields are ignored.
// R13: with the short discard option selected the discard timer expires after 64 clocks.
package brpf_pkg;
    // =========================================================================
    // register map
    localparam logic [7:0] BRPF_OFS_IRQ  = 8'h3c;
    localparam logic [7:0] BRPF_OFS_BUF  = 8'h40;
    localparam logic [7:0] BRPF_OFS_DISC = 8'h48;
    // =========================================================================
    // reset values and field positions
    localparam logic [7:0] BRPF_IRQ_ROUTE_RST = 8'h00;
    localparam logic [7:0] BRPF_PIN_FWD       = 8'h00;
    localparam logic [7:0] BRPF_PIN_REV       = 8'h01;
    localparam logic [7:0] BRPF_BUF_RST       = 8'h20;
    localparam logic [7:0] BRPF_BUF_WMASK     = 8'hf7;
    localparam int         BRPF_BIT_PARK      = 0;
    localparam int         BRPF_BIT_DYN_DIS   = 1;
    localparam int         BRPF_BIT_PRED_DIS  = 2;
    localparam int         BRPF_MULT_LSB      = 4;
    localparam int         BRPF_LINE_LSB      = 6;
    localparam logic [1:0] BRPF_PF_ONE_LINE   = 2'h0;
    localparam logic [1:0] BRPF_PF_KEEP_ONE   = 2'h1;
    localparam logic [1:0] BRPF_PF_FULL       = 2'h2;
    localparam logic [1:0] BRPF_PF_KEEP_BOTH  = 2'h3;
    // =========================================================================
    // discard timer
    localparam int BRPF_CLK_MHZ          = 100;
    localparam int BRPF_DISC_SHORT_CLKS  = 64;
    localparam int BRPF_DISC_LONG_CLKS   = 1024;
    localparam int BRPF_CNT_W            = 16;
    // =========================================================================
    // prefetch policy handed to the read datapath
    typedef struct packed {
        logic full;        // prefetch to the end of the window
        logic one_line;    // fetch one cache line only
        logic keep_master; // keep leftovers when the master ends the burst
        logic keep_bridge; // keep leftovers when the bridge disconnects
    } brpf_policy_type;
endpackage : brpf_pkg

// ==== brpf_regs.sv ====
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module brpf_regs
    import brpf_pkg::*;
#(
    parameter logic [7:0] MIN_GRANT       = 8'h00,
    parameter logic [7:0] MAX_LATENCY     = 8'h00,
    parameter int         DISC_LONG_CLKS  = BRPF_DISC_LONG_CLKS
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // classic wishbone slave
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    input  wire logic            we_i,
    input  wire logic [7:0]      adr_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic [31:0]     dat_i,
    output logic      [31:0]     dat_o,
    output logic                 ack_o,
    // bridge mode strap
    input  wire logic            reverse_mode_i,
    // secondary arbiter
    output logic                 park_on_bridge_o,
    // upstream read control
    output logic                 dyn_prefetch_en_o,
    output logic                 cpl_predict_en_o,
    input  wire logic            pcix_mode_i,
    input  wire logic            rd_valid_i,
    input  wire logic            rd_multiple_i,
    input  wire logic            rd_prefetchable_i,
    output brpf_policy_type      rd_policy_o,
    // retained data discard timer
    input  wire logic            retain_start_i,
    input  wire logic            retain_done_i,
    output logic                 discard_expire_o
);
    // =========================================================================
    // state
    logic [7:0]            irq_route_reg;
    logic [7:0]            buf_ctrl_reg;
    logic                  disc_short_reg;
    logic                  reverse_reg;
    logic                  ack_reg;
    logic [31:0]           dat_reg;
    logic [31:0]           dat_next;
    logic                  timer_run_reg;
    logic [BRPF_CNT_W-1:0] timer_cnt_reg;
    logic [BRPF_CNT_W-1:0] timer_load;
    brpf_policy_type       policy_reg;
    brpf_policy_type       policy_next;
    logic                  expire_reg;
    logic                  req;
    logic                  wr;

    localparam logic [BRPF_CNT_W-1:0] DISC_SHORT = BRPF_CNT_W'(BRPF_DISC_SHORT_CLKS);
    localparam logic [BRPF_CNT_W-1:0] DISC_LONG  = BRPF_CNT_W'(DISC_LONG_CLKS);

    // =========================================================================
    // field decode, shared by both read commands
    function automatic brpf_policy_type decode_pf(input logic [1:0] mode,
                                                  input logic       multiple);
        brpf_policy_type p;
        p = '0;
        case (mode)
            BRPF_PF_ONE_LINE: p.one_line = 1'b1;
            BRPF_PF_FULL:     p.full     = 1'b1;
            BRPF_PF_KEEP_ONE: begin
                p.full = 1'b1;
                // the two commands differ on which end's termination keeps data
                if (multiple) begin
                    p.keep_bridge = 1'b1;                 // [R9]
                end else begin
                    p.keep_master = 1'b1;                 // [R11]
                end
            end
            default: begin
                p.full        = 1'b1;
                p.keep_master = 1'b1;                     // [R9] [R11]
                p.keep_bridge = 1'b1;
            end
        endcase
        return p;
    endfunction : decode_pf

    // =========================================================================
    // bus handshake: one wait state, ack drops the cycle after it is given
    assign req = cyc_i && stb_i && !ack_reg;
    assign wr  = req && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // =========================================================================
    // mode strap caught while reset is held, kept afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reverse_reg <= reverse_mode_i;
        end
    end

    // =========================================================================
    // writable registers; bit 3 of the control byte stays zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_route_reg  <= BRPF_IRQ_ROUTE_RST;                  // [R1]
            buf_ctrl_reg   <= BRPF_BUF_RST;                        // [R8] [R10]
            disc_short_reg <= 1'b0;
        end else if (wr && sel_i[0]) begin
            if (adr_i == BRPF_OFS_IRQ) begin
                irq_route_reg <= dat_i[7:0];                       // [R1]
            end else if (adr_i == BRPF_OFS_BUF) begin
                buf_ctrl_reg <= dat_i[7:0] & BRPF_BUF_WMASK;
            end else if (adr_i == BRPF_OFS_DISC) begin
                disc_short_reg <= dat_i[0];
            end
        end
    end

    // =========================================================================
    // read mux; unmapped words read zero and still get ack
    always_comb begin
        dat_next = 32'h0000_0000;
        if (adr_i == BRPF_OFS_IRQ) begin
            dat_next = {MAX_LATENCY, MIN_GRANT,                    // [R3] [R4]
                        reverse_reg ? BRPF_PIN_REV : BRPF_PIN_FWD, // [R2]
                        irq_route_reg};
        end else if (adr_i == BRPF_OFS_BUF) begin
            dat_next = {24'h00_0000, buf_ctrl_reg};
        end else if (adr_i == BRPF_OFS_DISC) begin
            dat_next = {30'h0000_0000, timer_run_reg, disc_short_reg};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_reg <= dat_next;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;

    // =========================================================================
    // static controls toward the arbiter and read engine
    assign park_on_bridge_o  = buf_ctrl_reg[BRPF_BIT_PARK];        // [R5]
    assign dyn_prefetch_en_o = !buf_ctrl_reg[BRPF_BIT_DYN_DIS];    // [R6]
    assign cpl_predict_en_o  = !buf_ctrl_reg[BRPF_BIT_PRED_DIS];   // [R7]

    // =========================================================================
    // per-read prefetch policy, registered so the datapath sees a clean word
    always_comb begin
        policy_next = '0;
        if (pcix_mode_i || !rd_prefetchable_i) begin
            policy_next = '0;                                      // [R12]
        end else if (rd_multiple_i) begin
            policy_next = decode_pf(buf_ctrl_reg[BRPF_MULT_LSB +: 2], 1'b1); // [R8]
        end else begin
            policy_next = decode_pf(buf_ctrl_reg[BRPF_LINE_LSB +: 2], 1'b0); // [R10]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            policy_reg <= '0;
        end else if (rd_valid_i) begin
            policy_reg <= policy_next;
        end
    end

    assign rd_policy_o = policy_reg;

    // =========================================================================
    // discard timer; a fresh start reloads, so a late start never cuts a hold short
    assign timer_load = disc_short_reg ? DISC_SHORT : DISC_LONG;   // [R13]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_run_reg <= 1'b0;
            timer_cnt_reg <= '0;
            expire_reg    <= 1'b0;
        end else begin
            expire_reg <= 1'b0;
            if (retain_start_i) begin
                timer_run_reg <= 1'b1;
                timer_cnt_reg <= timer_load - 1'b1;
            end else if (retain_done_i) begin
                timer_run_reg <= 1'b0;
            end else if (timer_run_reg) begin
                if (timer_cnt_reg == '0) begin
                    timer_run_reg <= 1'b0;
                    expire_reg    <= 1'b1;                         // [R13]
                end else begin
                    timer_cnt_reg <= timer_cnt_reg - 1'b1;
                end
            end
        end
    end

    assign discard_expire_o = expire_reg;

    // =========================================================================
    // checker-side count of the discard hold, kept apart from the timer so that
    // a wrong reload value or a missed cancel shows up as a count mismatch
    logic                  chk_live_reg;
    logic                  chk_short_reg;
    logic [BRPF_CNT_W-1:0] chk_age_reg;

    // saturates rather than wraps, so a stale hold can never alias a fresh count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_live_reg  <= 1'b0;
            chk_short_reg <= 1'b0;
            chk_age_reg   <= '0;
        end else if (retain_start_i) begin
            chk_live_reg  <= 1'b1;
            chk_short_reg <= disc_short_reg;
            chk_age_reg   <= BRPF_CNT_W'(1);
        end else if (retain_done_i) begin
            chk_live_reg  <= 1'b0;
        end else if (chk_live_reg && chk_age_reg != '1) begin
            chk_age_reg   <= chk_age_reg + 1'b1;
        end
    end

    // =========================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_irq;
        req && !we_i && adr_i == BRPF_OFS_IRQ;
    endsequence

    a_irq_route_reset: assert property ($fell(rst_i) |-> irq_route_reg == 8'h00) // [R1]
        else $error("routing byte not zero after reset");
    a_pin_byte_mode: assert property (s_rd_irq |=>                 // [R2]
        dat_o[15:8] == (reverse_reg ? 8'h01 : 8'h00))
        else $error("interrupt pin byte wrong for mode");
    a_min_grant_ro: assert property (s_rd_irq |=> dat_o[23:16] == MIN_GRANT) // [R3]
        else $error("minimum grant byte changed");
    a_max_lat_ro: assert property (s_rd_irq |=> dat_o[31:24] == MAX_LATENCY) // [R4]
        else $error("maximum latency byte changed");
    a_park_follows_bit: assert property (                          // [R5]
        wr && sel_i[0] && adr_i == BRPF_OFS_BUF |=> park_on_bridge_o == $past(dat_i[0]))
        else $error("park select did not follow write");
    a_dyn_pred_ctrl: assert property (                             // [R6] [R7]
        wr && sel_i[0] && adr_i == BRPF_OFS_BUF |=>
        dyn_prefetch_en_o == !$past(dat_i[1]) && cpl_predict_en_o == !$past(dat_i[2]))
        else $error("dynamic or prediction enable did not follow write");
    a_mult_policy: assert property (rd_valid_i && rd_multiple_i && rd_prefetchable_i
        && !pcix_mode_i && buf_ctrl_reg[5:4] == 2'h1 |=>           // [R9]
        rd_policy_o.full && rd_policy_o.keep_bridge && !rd_policy_o.keep_master)
        else $error("read multiple keep mode wrong");
    a_line_policy: assert property (rd_valid_i && !rd_multiple_i && rd_prefetchable_i
        && !pcix_mode_i && buf_ctrl_reg[7:6] == 2'h0 |=>           // [R10]
        rd_policy_o == 4'b0100)
        else $error("read line one-line mode wrong");
    a_pcix_ignore: assert property (rd_valid_i && pcix_mode_i |=> rd_policy_o == '0) // [R12]
        else $error("prefetch fields used in pci-x mode");
    // the expiry shows in the cycle after the count's last edge, hence the extra one
    a_short_discard: assert property (chk_live_reg && chk_short_reg // [R13]
        && chk_age_reg == DISC_SHORT + 1'b1 |-> discard_expire_o)
        else $error("short discard timer not 64 clocks");
    a_discard_when: assert property (discard_expire_o |->          // [R13]
        chk_live_reg && chk_age_reg == (chk_short_reg ? DISC_SHORT : DISC_LONG) + 1'b1)
        else $error("discard expiry at the wrong count");
    a_expire_pulse: assert property (discard_expire_o |=> !discard_expire_o) // [R13]
        else $error("discard expiry longer than one cycle");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held more than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged in one cycle");

    // hardware defaults seen by the arbiter and read engine right after reset
    a_ctrl_reset: assert property ($fell(rst_i) |->                // [R5] [R6] [R7]
        !park_on_bridge_o && dyn_prefetch_en_o && cpl_predict_en_o)
        else $error("control outputs not at defaults after reset");
    a_route_write: assert property (wr && sel_i[0] && adr_i == BRPF_OFS_IRQ |=> // [R1]
        irq_route_reg == $past(dat_i[7:0]))
        else $error("routing byte did not take the write");
    // the reserved control bit must never read back as one
    a_bit3_zero: assert property (!buf_ctrl_reg[3])
        else $error("reserved control bit set");

    // more prefetch settings, not read-multiple 00 or read-line 10; both commands share the keep-on-either-end value
    a_mult_full: assert property (rd_valid_i && rd_multiple_i && rd_prefetchable_i // [R8]
        && !pcix_mode_i && buf_ctrl_reg[5:4] == 2'h2 |=> rd_policy_o == 4'b1000)
        else $error("read multiple full mode wrong");
    a_line_keep: assert property (rd_valid_i && !rd_multiple_i && rd_prefetchable_i // [R11]
        && !pcix_mode_i && buf_ctrl_reg[7:6] == 2'h1 |=> rd_policy_o == 4'b1010)
        else $error("read line keep mode wrong");
    a_keep_both: assert property (rd_valid_i && rd_prefetchable_i && !pcix_mode_i // [R9] [R11]
        && (rd_multiple_i ? buf_ctrl_reg[5:4] : buf_ctrl_reg[7:6]) == 2'h3
        |=> rd_policy_o == 4'b1011)
        else $error("keep on either termination wrong");
    // a read outside the prefetchable range never prefetches
    a_nonpf_zero: assert property (rd_valid_i && !rd_prefetchable_i |=> // [R8] [R10]
        rd_policy_o == '0)
        else $error("prefetch policy outside prefetchable range");
endmodule : brpf_regs

// ==== brpf_read_master.sv ====
`timescale 1ns/10ps
// =============================================================
// upstream read source and retained-data owner beside the block
module brpf_read_master (
    input  wire logic clk_i,
    output logic      rd_valid_o,
    output logic      rd_multiple_o,
    output logic      rd_prefetchable_o,
    output logic      pcix_mode_o,
    output logic      retain_start_o,
    output logic      retain_done_o
);
    // idle between requests; command lines are toggled so stale values never look valid
    initial begin
        {rd_valid_o, rd_multiple_o, rd_prefetchable_o} = 3'h0;
        {pcix_mode_o, retain_start_o, retain_done_o} = 3'h0;
    end
    // one read request, held for exactly the edge that takes it
    task automatic issue(input logic mult, input logic pf, input logic pcix);
        @(posedge clk_i);
        rd_valid_o        <= 1'b1;
        rd_multiple_o     <= mult;
        rd_prefetchable_o <= pf;
        pcix_mode_o       <= pcix;
        @(posedge clk_i);
        rd_valid_o        <= 1'b0;
        rd_multiple_o     <= ~mult;
        rd_prefetchable_o <= ~pf;
    endtask : issue
    // leftover data kept after a burst ends: start the discard count
    task automatic retain;
        @(posedge clk_i);
        retain_start_o <= 1'b1;
        @(posedge clk_i);
        retain_start_o <= 1'b0;
    endtask : retain
    // leftover data claimed or dropped early: the discard count must stop
    task automatic release_hold;
        @(posedge clk_i);
        retain_done_o <= 1'b1;
        @(posedge clk_i);
        retain_done_o <= 1'b0;
    endtask : release_hold
endmodule : brpf_read_master

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import brpf_pkg::*;
    localparam int LONG_CLKS = 16;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]      adr_i = 8'h00;
    logic [3:0]      sel_i = 4'h0;
    logic [31:0]     dat_i = 32'h0, dat_o, q;
    logic            ack_o, park_o, dyn_o, pred_o, expire_o;
    logic            rv, rm, rp, px, rs, rd;
    logic            rev_i = 1'b1;
    brpf_policy_type pol_o;
    int              miscompares = 0, compares = 0, n;
    // =============================================================
    // clock, design and partner
    always #5 clk_i = ~clk_i;
    brpf_regs #(.DISC_LONG_CLKS(LONG_CLKS)) brpf_regs_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .reverse_mode_i(rev_i),
        .park_on_bridge_o(park_o), .dyn_prefetch_en_o(dyn_o), .cpl_predict_en_o(pred_o),
        .pcix_mode_i(px), .rd_valid_i(rv), .rd_multiple_i(rm), .rd_prefetchable_i(rp),
        .rd_policy_o(pol_o), .retain_start_i(rs), .retain_done_i(rd),
        .discard_expire_o(expire_o));
    brpf_read_master brpf_read_master_i (.clk_i(clk_i), .rd_valid_o(rv), .rd_multiple_o(rm),
        .rd_prefetchable_o(rp), .pcix_mode_o(px), .retain_start_o(rs), .retain_done_o(rd));
    // =============================================================
    // checking and reporting
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_pol(input brpf_policy_type got, input brpf_policy_type exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t policy %b expected %b", $time, got, exp);
        end
    endtask : cmp_pol
    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
        // no cycle limit of its own: a missing ack is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
        dat_i <= ~d;
    endtask : wb
    // reference mapping of a prefetch field onto the policy outputs
    function automatic brpf_policy_type exp_pol(input logic [1:0] f, input logic mult);
        case (f)
            2'h0: exp_pol = 4'b0100;
            2'h1: exp_pol = mult ? 4'b1001 : 4'b1010;
            2'h2: exp_pol = 4'b1000;
            default: exp_pol = 4'b1011;
        endcase
    endfunction : exp_pol
    // discard count from start until the expiry pulse, bounded
    task automatic time_discard(input int exp);
        brpf_read_master_i.retain();
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (expire_o !== 1'b1 && n < 2000);
        cmp_data(32'(n), 32'(exp));
    endtask : time_discard
    // =============================================================
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    // =============================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, BRPF_OFS_IRQ, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0100);
        wb(1'b0, BRPF_OFS_BUF, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0020);
        cmp_data({29'h0, park_o, dyn_o, pred_o}, 32'h3);
        wb(1'b1, BRPF_OFS_IRQ, 32'hffff_ffff, 4'hf);
        wb(1'b1, BRPF_OFS_IRQ, 32'h0000_0055, 4'he);
        wb(1'b0, BRPF_OFS_IRQ, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_01ff);
        wb(1'b0, 8'h44, 32'h0, 4'hf);
        cmp_data(q, 32'h0);
        wb(1'b1, BRPF_OFS_BUF, 32'h0000_00ff, 4'hf);
        wb(1'b0, BRPF_OFS_BUF, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_00f7);
        cmp_data({29'h0, park_o, dyn_o, pred_o}, 32'h4);
        // every prefetch setting for both read commands
        for (int v = 0; v < 4; v++) begin
            wb(1'b1, BRPF_OFS_BUF, {24'h0, 2'(v), 2'(v), 4'h0}, 4'hf);
            brpf_read_master_i.issue(1'b1, 1'b1, 1'b0);
            #1;
            cmp_pol(pol_o, exp_pol(2'(v), 1'b1));
            brpf_read_master_i.issue(1'b0, 1'b1, 1'b0);
            #1;
            cmp_pol(pol_o, exp_pol(2'(v), 1'b0));
        end
        brpf_read_master_i.issue(1'b1, 1'b1, 1'b1);
        #1;
        cmp_pol(pol_o, 4'b0000);
        brpf_read_master_i.issue(1'b0, 1'b0, 1'b0);
        #1;
        cmp_pol(pol_o, 4'b0000);
        // discard timer, long then short duration
        time_discard(LONG_CLKS);
        wb(1'b1, BRPF_OFS_DISC, 32'h1, 4'hf);
        time_discard(BRPF_DISC_SHORT_CLKS);
        // a cancelled hold never expires; the running flag reads back meanwhile
        brpf_read_master_i.retain();
        wb(1'b0, BRPF_OFS_DISC, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0003);
        brpf_read_master_i.release_hold();
        n = 0;
        repeat (80) begin
            @(posedge clk_i);
            #1;
            if (expire_o !== 1'b0) n++;
        end
        cmp_data(32'(n), 32'h0);
        wb(1'b0, BRPF_OFS_DISC, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0001);
        // second reset in mid-run, strap now in forward position
        @(posedge clk_i);
        rst_i <= 1'b1;
        rev_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, BRPF_OFS_IRQ, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0000);
        wb(1'b0, BRPF_OFS_BUF, 32'h0, 4'hf);
        cmp_data(q, 32'h0000_0020);
        cmp_data({29'h0, park_o, dyn_o, pred_o}, 32'h3);
        complete_run();
    end
endmodule : testbench
